/* File: include/cstg_defines.vh */
// Constants for the self-test and service gate: offsets, fields, codes, counts.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef CSTG_DEFINES_VH
`define CSTG_DEFINES_VH
`define CSTG_ADR_STATUS 8'h00
`define CSTG_ADR_CMD 8'h04
`define CSTG_ADR_RESP 8'h08
`define CSTG_ADR_DIGSEL 8'h0c
`define CSTG_ADR_DIGEST 8'h10
`define CSTG_FLASH_WORDS 18'h10000
`define CSTG_CRC_INIT 32'hffffffff
`define CSTG_CRC_POLY 32'hedb88320
`define CSTG_KAT_LAST 4'ha
`define CSTG_OP_FWAUTH 4'hb
`define CSTG_OP_LOGIN 4'hc
`define CSTG_OP_UNWRAP 4'hd
`define CSTG_OP_DIAGK 4'he
`define CSTG_OP_DIAGH 4'hf
`define CSTG_SVC_RESET 5'h00
`define CSTG_SVC_LOGIN 5'h01
`define CSTG_SVC_LOGOUT 5'h02
`define CSTG_SVC_GETOP 5'h03
`define CSTG_SVC_GETCFG 5'h04
`define CSTG_SVC_SHOWST 5'h05
`define CSTG_SVC_CONFIG 5'h06
`define CSTG_SVC_OPMGT 5'h07
`define CSTG_SVC_DIAG 5'h08
`define CSTG_SVC_DECRYPT 5'h09
`define CSTG_SVC_ENCRYPT 5'h0a
`define CSTG_SVC_DEKMGT 5'h0b
`define CSTG_SVC_KEKMGT 5'h0c
`define CSTG_SVC_HKEYMGT 5'h0d
`define CSTG_SVC_FWUPD 5'h0e
`define CSTG_ROLE_NONE 2'h0
`define CSTG_ROLE_USER 2'h1
`define CSTG_ROLE_OFFICER 2'h2
`define CSTG_KEY_DEK 3'h0
`define CSTG_KEY_KEK 3'h1
`define CSTG_KEY_FACTORY_INITIAL_WRAP_KEY 3'h2
`define CSTG_KEY_OPKEY 3'h3
`define CSTG_KEY_HMAC 3'h4
`define CSTG_KEY_NONE 3'h7
`define CSTG_ILA_RUN 2'h0
`define CSTG_ILA_OK 2'h1
`define CSTG_ILA_FAIL 2'h2
`define CSTG_ENC_RUN 2'h0
`define CSTG_ENC_FAIL 2'h1
`define CSTG_ENC_OK 2'h3
`define CSTG_FAIL_AES 8'h01
`define CSTG_FAIL_SHA 8'h02
`define CSTG_FAIL_KW 8'h04
`define CSTG_RSP_OK 32'h00000000
`define CSTG_RSP_DENIED 32'h00000001
`define CSTG_RSP_FATAL 32'h00000002
`define CSTG_RSP_IOBUSY 32'h00000003
`define CSTG_RSP_BADCMD 32'h00000004
`define CSTG_RSP_AUTHFAIL 32'h00000005
`define CSTG_RSP_TESTFAIL 32'h00000006
`define CSTG_RSP_LOGGED 32'h00000007
`define CSTG_RSP_FWFAIL 32'h0000000e
`endif

/* File: hdl/cstg_service_gate.v */
// Self-test sequencer, role gate and service dispatcher of the encryption module.
// Assumes external engines that stream compare words and flash that answers reads.
//
// Behaviour
// - Every reset starts the full power-up self-test run before anything else.
// - No cryptographic service runs until integrity check and all known-answer tests pass.
// - Integrity or known-answer test failure enters the fatal error state.
// - Integrity failure sets image-loader field to binary 10 and halts boot.
// - Any known-answer failure sets encryption-capability field to binary 01.
// - Eight further status bits name the failing engine: cipher, hash or wrap.
// - Integrity check is a 32-bit CRC over all program words in flash.
// - Keyed-hash known-answer test checks SHA-1, -224, -256, -384 and -512.
// - Self-tests start unprompted; conditional tests run when their function is used.
// - Firmware images are keyed-hashed with SHA-256 and image key, then compared.
// - Firmware digest mismatch rejects the update with response 0x0000000E.
// - Diagnostic engine test runs only while no I/O message blocks are active.
// - Positive known-answer diagnostic case passes on match; negative case passes on mismatch.
// - Diagnostic keyed-hash test returns the computed digest to the host.
// - Diagnostic test alters hardware; a module reset restores normal operation.
// - Officer: configure, diagnostics. User: encrypt, decrypt. Both: key, operator, firmware.
// - Reset, login, logout, operator query, config read, status need no authentication.
// - Logout succeeds even when nobody is logged in.
// - Module status is shown on indicator lights and status register bits.
// - Encrypt and decrypt use the data key in XTS; data key unwrapped with wrap key.
// - Wrap-key management uses, writes and erases factory and current wrap keys.
// - Only one operator at a time; another login needs a logout first.
// - Data and image keys erase to 0x00, all other keys to 0xFF.
// - Hardware reset clears all volatile state; the reset service drops the operator but keeps configuration and digest words.
`timescale 1ns/10ps
`include "cstg_defines.vh"
module cstg_service_gate #(
  parameter [17:0] FLASH_WORDS = `CSTG_FLASH_WORDS
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Flash reader
  output reg flashRd,
  output reg [17:0] flashAddr,
  input wire [31:0] flashData,
  input wire flashAck,
  // Engine jobs
  output reg engStart,
  output reg [3:0] engOp,
  output reg [2:0] engKey,
  input wire cmpValid,
  input wire [31:0] cmpCalc,
  input wire [31:0] cmpRef,
  input wire engDone,
  // Key store
  output reg keyWe,
  output reg [2:0] keyId,
  output reg keyErase,
  output reg [7:0] keyFill,
  // Data path
  output reg xtsGo,
  output reg xtsDecrypt,
  input wire ioActive,
  // Indicators
  output reg ledReady,
  output reg ledFatal,
  output reg ledBusy,
  output reg dataOutEn,
  output reg bootHalt,
  output reg diagActive
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CRC = 3'h1;
  localparam [2:0] ST_CRCW = 3'h2;
  localparam [2:0] ST_KAT = 3'h3;
  localparam [2:0] ST_JOB = 3'h4;
  localparam [2:0] JK_SELF = 3'h0;
  localparam [2:0] JK_FW = 3'h1;
  localparam [2:0] JK_LOGIN = 3'h2;
  localparam [2:0] JK_KEYW = 3'h3;
  localparam [2:0] JK_DIAGK = 3'h4;
  localparam [2:0] JK_DIAGH = 3'h5;

  reg [2:0] state_q;
  reg [2:0] jobKind_q;
  reg [31:0] crc_q;
  reg [3:0] katIdx_q;
  reg mismatch_q;
  reg negCase_q;
  reg [1:0] ilaStat_q;
  reg [1:0] encStat_q;
  reg [7:0] engFail_q;
  reg fatal_q;
  reg ready_q;
  reg [1:0] role_q;
  reg [1:0] pendRole_q;
  reg [2:0] pendKey_q;
  reg diag_q;
  reg [15:0] cfg_q;
  reg [31:0] resp_q;
  reg done_q;
  reg [2:0] digSel_q;
  reg [2:0] wordCnt_q;
  reg [31:0] digMem [0:7];
  integer i;

  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWr = wbReq & wb_we_i;
  wire cmdWr = wbWr & (wb_adr_i == `CSTG_ADR_CMD) & (wb_sel_i == 4'hf);
  wire [4:0] svc = wb_dat_i[4:0];
  wire [31:0] status = {12'h000, done_q, diag_q, role_q, (role_q != `CSTG_ROLE_NONE),
    (state_q != ST_IDLE), ready_q, fatal_q, engFail_q, encStat_q, ilaStat_q};

  function [31:0] crcWord;
    input [31:0] c;
    input [31:0] d;
    integer b;
    reg [31:0] r;
    begin
      r = c ^ d;
      for (b = 0; b < 32; b = b + 1) begin
        r = r[0] ? ((r >> 1) ^ `CSTG_CRC_POLY) : (r >> 1);
      end
      crcWord = r;
    end
  endfunction

  // Which engine a power-up test exercises: 0-1 ECB, 2-3 XTS, 4-5 wrap, 6-10 keyed hash
  function [7:0] failBit;
    input [3:0] idx;
    begin
      if (idx < 4'h4) begin
        failBit = `CSTG_FAIL_AES;
      end else if (idx < 4'h6) begin
        failBit = `CSTG_FAIL_KW;
      end else begin
        failBit = `CSTG_FAIL_SHA;
      end
    end
  endfunction

  function allowed;
    input [4:0] s;
    input [1:0] r;
    begin
      case (s)
        `CSTG_SVC_CONFIG, `CSTG_SVC_DIAG: allowed = (r == `CSTG_ROLE_OFFICER);
        `CSTG_SVC_DECRYPT, `CSTG_SVC_ENCRYPT: allowed = (r == `CSTG_ROLE_USER);
        `CSTG_SVC_OPMGT, `CSTG_SVC_DEKMGT, `CSTG_SVC_KEKMGT, `CSTG_SVC_HKEYMGT,
        `CSTG_SVC_FWUPD: allowed = (r != `CSTG_ROLE_NONE);
        default: allowed = 1'b1;
      endcase
    end
  endfunction

  function isCrypto;
    input [4:0] s;
    begin
      isCrypto = (s >= `CSTG_SVC_OPMGT) | (s == `CSTG_SVC_LOGIN);
    end
  endfunction

  // Bus slave: one wait state, unmapped reads give zero, unmapped writes vanish
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      digSel_q <= 3'h0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq & ~wb_we_i) begin
        case (wb_adr_i)
          `CSTG_ADR_STATUS: wb_dat_o <= status;
          `CSTG_ADR_RESP: wb_dat_o <= resp_q;
          `CSTG_ADR_DIGSEL: wb_dat_o <= {29'h0, digSel_q};
          `CSTG_ADR_DIGEST: wb_dat_o <= digMem[digSel_q];
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wbWr & (wb_adr_i == `CSTG_ADR_DIGSEL) & wb_sel_i[0]) begin
        digSel_q <= wb_dat_i[2:0];
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_CRC;
      jobKind_q <= JK_SELF;
      crc_q <= `CSTG_CRC_INIT;
      katIdx_q <= 4'h0;
      mismatch_q <= 1'b0;
      negCase_q <= 1'b0;
      ilaStat_q <= `CSTG_ILA_RUN;
      encStat_q <= `CSTG_ENC_RUN;
      engFail_q <= 8'h00;
      fatal_q <= 1'b0;
      ready_q <= 1'b0;
      role_q <= `CSTG_ROLE_NONE;
      pendRole_q <= `CSTG_ROLE_NONE;
      pendKey_q <= `CSTG_KEY_NONE;
      diag_q <= 1'b0;
      cfg_q <= 16'h0000;
      resp_q <= `CSTG_RSP_OK;
      done_q <= 1'b0;
      wordCnt_q <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        digMem[i] <= 32'h00000000;
      end
      flashRd <= 1'b0;
      flashAddr <= 18'h00000;
      engStart <= 1'b0;
      engOp <= 4'h0;
      engKey <= `CSTG_KEY_NONE;
      keyWe <= 1'b0;
      keyId <= `CSTG_KEY_NONE;
      keyErase <= 1'b0;
      keyFill <= 8'h00;
      xtsGo <= 1'b0;
      xtsDecrypt <= 1'b0;
    end else begin
      flashRd <= 1'b0;
      engStart <= 1'b0;
      keyWe <= 1'b0;
      xtsGo <= 1'b0;
      case (state_q)
        ST_CRC: begin
          flashRd <= 1'b1;
          state_q <= ST_CRCW;
        end
        ST_CRCW: begin
          if (flashAck) begin
            // Last flash word holds the stored checksum of all words before it
            if (flashAddr == FLASH_WORDS - 18'h1) begin
              if ((crc_q ^ `CSTG_CRC_INIT) == flashData) begin
                ilaStat_q <= `CSTG_ILA_OK;
                katIdx_q <= 4'h0;
                state_q <= ST_KAT;
              end else begin
                ilaStat_q <= `CSTG_ILA_FAIL;
                fatal_q <= 1'b1;
                state_q <= ST_IDLE;
              end
            end else begin
              crc_q <= crcWord(crc_q, flashData);
              flashAddr <= flashAddr + 18'h1;
              state_q <= ST_CRC;
            end
          end
        end
        ST_KAT: begin
          // Index 6..10 runs hash verification for each of the five digest sizes
          engStart <= 1'b1;
          engOp <= katIdx_q;
          engKey <= `CSTG_KEY_NONE;
          jobKind_q <= JK_SELF;
          negCase_q <= 1'b0;
          mismatch_q <= 1'b0;
          state_q <= ST_JOB;
        end
        ST_JOB: begin
          if (cmpValid) begin
            if (cmpCalc != cmpRef) begin
              mismatch_q <= 1'b1;
            end
            if (jobKind_q == JK_DIAGH) begin
              digMem[wordCnt_q] <= cmpCalc;
              wordCnt_q <= wordCnt_q + 3'h1;
            end
          end
          if (engDone) begin
            state_q <= ST_IDLE;
            done_q <= (jobKind_q != JK_SELF);
            case (jobKind_q)
              JK_SELF: begin
                if (mismatch_q) begin
                  encStat_q <= `CSTG_ENC_FAIL;
                  engFail_q <= engFail_q | failBit(katIdx_q);
                  fatal_q <= 1'b1;
                end else if (katIdx_q == `CSTG_KAT_LAST) begin
                  encStat_q <= `CSTG_ENC_OK;
                  ready_q <= 1'b1;
                end else begin
                  katIdx_q <= katIdx_q + 4'h1;
                  state_q <= ST_KAT;
                end
              end
              JK_FW: begin
                resp_q <= mismatch_q ? `CSTG_RSP_FWFAIL : `CSTG_RSP_OK;
              end
              JK_LOGIN: begin
                if (mismatch_q) begin
                  resp_q <= `CSTG_RSP_AUTHFAIL;
                end else begin
                  role_q <= pendRole_q;
                  resp_q <= `CSTG_RSP_OK;
                end
              end
              JK_KEYW: begin
                if (mismatch_q) begin
                  resp_q <= `CSTG_RSP_AUTHFAIL;
                end else begin
                  keyWe <= 1'b1;
                  keyId <= pendKey_q;
                  keyErase <= 1'b0;
                  resp_q <= `CSTG_RSP_OK;
                end
              end
              JK_DIAGK: begin
                // Negative cases must disagree with the known answer to pass
                resp_q <= (mismatch_q ^ negCase_q) ? `CSTG_RSP_TESTFAIL
                  : `CSTG_RSP_OK;
              end
              default: begin
                resp_q <= `CSTG_RSP_OK;
              end
            endcase
          end
        end
        default: begin
          // Commands are ignored while self-tests or a job run
          if (cmdWr) begin
            done_q <= 1'b1;
            mismatch_q <= 1'b0;
            negCase_q <= wb_dat_i[8];
            wordCnt_q <= 3'h0;
            resp_q <= `CSTG_RSP_OK;
            if (!allowed(svc, role_q)) begin
              resp_q <= `CSTG_RSP_DENIED;
            end else if (isCrypto(svc) & (fatal_q | ~ready_q)) begin
              resp_q <= `CSTG_RSP_FATAL;
            end else begin
              case (svc)
                `CSTG_SVC_RESET: begin
                  // Soft reset reruns the tests and drops login and diagnostic mode
                  state_q <= ST_CRC;
                  crc_q <= `CSTG_CRC_INIT;
                  flashAddr <= 18'h00000;
                  ilaStat_q <= `CSTG_ILA_RUN;
                  encStat_q <= `CSTG_ENC_RUN;
                  engFail_q <= 8'h00;
                  fatal_q <= 1'b0;
                  ready_q <= 1'b0;
                  role_q <= `CSTG_ROLE_NONE;
                  diag_q <= 1'b0;
                end
                `CSTG_SVC_LOGOUT: begin
                  role_q <= `CSTG_ROLE_NONE;
                end
                `CSTG_SVC_GETOP: begin
                  resp_q <= {30'h0, role_q};
                end
                `CSTG_SVC_GETCFG: begin
                  resp_q <= {16'h0000, cfg_q};
                end
                `CSTG_SVC_SHOWST: begin
                  resp_q <= status;
                end
                `CSTG_SVC_CONFIG: begin
                  cfg_q <= wb_dat_i[31:16];
                end
                `CSTG_SVC_LOGIN: begin
                  if (role_q != `CSTG_ROLE_NONE) begin
                    resp_q <= `CSTG_RSP_LOGGED;
                  end else begin
                    pendRole_q <= wb_dat_i[17:16];
                    engStart <= 1'b1;
                    engOp <= `CSTG_OP_LOGIN;
                    engKey <= `CSTG_KEY_OPKEY;
                    jobKind_q <= JK_LOGIN;
                    state_q <= ST_JOB;
                  end
                end
                `CSTG_SVC_DIAG: begin
                  if (ioActive) begin
                    resp_q <= `CSTG_RSP_IOBUSY;
                  end else begin
                    diag_q <= 1'b1;
                    engStart <= 1'b1;
                    engOp <= wb_dat_i[9] ? `CSTG_OP_DIAGH : `CSTG_OP_DIAGK;
                    engKey <= `CSTG_KEY_NONE;
                    jobKind_q <= wb_dat_i[9] ? JK_DIAGH : JK_DIAGK;
                    state_q <= ST_JOB;
                  end
                end
                `CSTG_SVC_DECRYPT, `CSTG_SVC_ENCRYPT: begin
                  if (diag_q) begin
                    resp_q <= `CSTG_RSP_DENIED;
                  end else begin
                    xtsGo <= 1'b1;
                    xtsDecrypt <= (svc == `CSTG_SVC_DECRYPT);
                    engKey <= `CSTG_KEY_DEK;
                  end
                end
                `CSTG_SVC_OPMGT, `CSTG_SVC_DEKMGT, `CSTG_SVC_KEKMGT,
                `CSTG_SVC_HKEYMGT: begin
                  if (wb_dat_i[8]) begin
                    keyWe <= 1'b1;
                    keyErase <= 1'b1;
                    keyId <= pickKey(svc, wb_dat_i[9]);
                    keyFill <= fillOf(pickKey(svc, wb_dat_i[9]));
                    negCase_q <= 1'b0;
                  end else begin
                    pendKey_q <= pickKey(svc, wb_dat_i[9]);
                    engStart <= 1'b1;
                    engOp <= `CSTG_OP_UNWRAP;
                    engKey <= wrapKey(pickKey(svc, wb_dat_i[9]));
                    jobKind_q <= JK_KEYW;
                    state_q <= ST_JOB;
                  end
                end
                `CSTG_SVC_FWUPD: begin
                  engStart <= 1'b1;
                  engOp <= `CSTG_OP_FWAUTH;
                  engKey <= `CSTG_KEY_HMAC;
                  jobKind_q <= JK_FW;
                  state_q <= ST_JOB;
                end
                default: begin
                  resp_q <= `CSTG_RSP_BADCMD;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  function [2:0] pickKey;
    input [4:0] s;
    input alt;
    begin
      case (s)
        `CSTG_SVC_OPMGT: pickKey = `CSTG_KEY_OPKEY;
        `CSTG_SVC_DEKMGT: pickKey = `CSTG_KEY_DEK;
        `CSTG_SVC_KEKMGT: pickKey = alt ? `CSTG_KEY_FACTORY_INITIAL_WRAP_KEY : `CSTG_KEY_KEK;
        default: pickKey = `CSTG_KEY_HMAC;
      endcase
    end
  endfunction

  // Wrap keys themselves arrive under the factory key; everything else under the wrap key
  function [2:0] wrapKey;
    input [2:0] k;
    begin
      wrapKey = ((k == `CSTG_KEY_KEK) | (k == `CSTG_KEY_FACTORY_INITIAL_WRAP_KEY)) ? `CSTG_KEY_FACTORY_INITIAL_WRAP_KEY
        : `CSTG_KEY_KEK;
    end
  endfunction

  function [7:0] fillOf;
    input [2:0] k;
    begin
      fillOf = ((k == `CSTG_KEY_DEK) | (k == `CSTG_KEY_HMAC)) ? 8'h00 : 8'hff;
    end
  endfunction

  // Indicators follow state one cycle later
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ledReady <= 1'b0;
      ledFatal <= 1'b0;
      ledBusy <= 1'b1;
      dataOutEn <= 1'b0;
      bootHalt <= 1'b0;
      diagActive <= 1'b0;
    end else begin
      ledReady <= ready_q & ~fatal_q;
      ledFatal <= fatal_q;
      ledBusy <= (state_q != ST_IDLE);
      dataOutEn <= ready_q & ~fatal_q & (state_q == ST_IDLE);
      bootHalt <= (ilaStat_q == `CSTG_ILA_FAIL);
      diagActive <= diag_q;
    end
  end
endmodule

/* File: hdl/cstg_service_gate_fns_note.v */
// Holds no logic.

/* File: bench/cstg_far_side.sv */
// Flash and engine model that faces the service gate.
// Assumes the bench sets its controls only while the gate is in reset or idle.
`timescale 1ns/10ps
module cstg_far_side (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Bench controls
  input wire badCrc,
  input wire slow,
  input wire [4:0] failOp,
  input wire [31:0] seedWord,
  // Flash
  input wire flashRd,
  input wire [17:0] flashAddr,
  output reg [31:0] flashData,
  output reg flashAck,
  // Engines
  input wire engStart,
  input wire [3:0] engOp,
  output reg cmpValid,
  output reg [31:0] cmpCalc,
  output reg [31:0] cmpRef,
  output reg engDone,
  output reg [31:0] opSeen
);
  reg [2:0] fl, ec;
  reg [17:0] fa;
  reg [3:0] op;
  // Reflected CRC over the three data words, fed low bit first
  function [31:0] crcOf(input [31:0] s);
    reg [31:0] c, w;
    integer i, b;
    begin
      c = 32'hffffffff;
      for (i = 0; i < 3; i = i + 1) begin
        w = s + 32'(i);
        for (b = 0; b < 32; b = b + 1)
          c = (c >> 1) ^ ((c[0] ^ w[b]) ? 32'hedb88320 : 32'h0);
      end
      crcOf = ~c;
    end
  endfunction
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fl <= 3'h0;
      ec <= 3'h0;
      flashAck <= 1'b0;
      cmpValid <= 1'b0;
      engDone <= 1'b0;
      opSeen <= 32'h0;
      flashData <= 32'h0;
      cmpCalc <= 32'h0;
      cmpRef <= 32'h0;
    end else begin
      flashAck <= 1'b0;
      cmpValid <= 1'b0;
      engDone <= 1'b0;
      // Idle lines toggle so stale words never pass as data
      flashData <= ~flashData;
      cmpCalc <= ~cmpCalc;
      cmpRef <= ~cmpRef;
      if (flashRd) begin
        fl <= slow ? 3'h3 : 3'h1;
        fa <= flashAddr;
      end else if (fl == 3'h1) begin
        fl <= 3'h0;
        flashAck <= 1'b1;
        flashData <= (fa == 18'h3) ? crcOf(seedWord) ^ {31'h0, badCrc} : seedWord + {14'h0, fa};
      end else if (fl != 3'h0) begin
        fl <= fl - 3'h1;
      end
      if (engStart) begin
        ec <= slow ? 3'h6 : 3'h3;
        op <= engOp;
        opSeen[engOp] <= 1'b1;
      end else if (ec != 3'h0) begin
        ec <= ec - 3'h1;
        engDone <= ec == 3'h1;
        if (ec == 3'h3 || ec == 3'h2) begin
          cmpValid <= 1'b1;
          cmpCalc <= {seedWord[27:0], op};
          cmpRef <= {seedWord[27:0], op} ^ {31'h0, {1'b0, op} == failOp};
        end
      end
    end
  end
endmodule

/* File: bench/cstg_service_gate_assertions.sv */
// Port checker for the service gate.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
module cstg_checker (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Flash and engines
  input wire flashRd,
  input wire [17:0] flashAddr,
  input wire engStart,
  input wire [3:0] engOp,
  input wire [2:0] engKey,
  input wire ioActive,
  // Keys and data
  input wire keyWe,
  input wire [2:0] keyId,
  input wire keyErase,
  input wire [7:0] keyFill,
  input wire xtsGo,
  // Indicators
  input wire ledReady,
  input wire ledFatal,
  input wire ledBusy,
  input wire dataOutEn,
  input wire bootHalt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sAck;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_bus_ack: assert property (sReq |=> sAck)
    else $error("ack not one cycle");
  chk_test_first: assert property ($rose(rst_b) |=> flashRd && flashAddr == 18'h0)
    else $error("self-test not started");
  chk_fatal_quiet: assert property (ledFatal |-> !ledReady && !dataOutEn && !xtsGo)
    else $error("fatal state serves data");
  chk_halt_fatal: assert property (bootHalt |-> ledFatal && !engStart)
    else $error("halt without fatal");
  chk_xts_gate: assert property (xtsGo |-> ledReady && engKey == 3'h0)
    else $error("data job not gated");
  chk_erase_fill: assert property (keyWe && keyErase |->
    keyFill == ((keyId == 3'h0 || keyId == 3'h4) ? 8'h00 : 8'hff))
    else $error("erase fill byte wrong");
  chk_diag_idle: assert property (engStart && engOp[3:1] == 3'h7 |-> !$past(ioActive))
    else $error("diag run while io active");
  chk_busy_ready: assert property (dataOutEn |-> ledReady && !ledBusy)
    else $error("data out while busy");
endmodule
bind cstg_service_gate cstg_checker chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flashRd(flashRd),
  .flashAddr(flashAddr), .engStart(engStart), .engOp(engOp), .engKey(engKey),
  .ioActive(ioActive), .keyWe(keyWe), .keyId(keyId), .keyErase(keyErase), .keyFill(keyFill),
  .xtsGo(xtsGo), .ledReady(ledReady), .ledFatal(ledFatal), .ledBusy(ledBusy),
  .dataOutEn(dataOutEn), .bootHalt(bootHalt));

/* File: bench/test_crypto_selftest_service_gate.sv */
// Self-checking bench for the service gate over classic Wishbone.
// Assumes the far-side model and the bound checker compile first.
`timescale 1ns/10ps
`include "cstg_defines.vh"
module test_crypto_selftest_service_gate;
  reg core_clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0;
  reg [3:0] sel = 4'hf;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg ioActive = 1'b0, badCrc = 1'b0, slow = 1'b0;
  reg [4:0] failOp = 5'h1f;
  reg [31:0] seedWord = 32'h0;
  reg [31:0] q;
  reg [31:0] keyCmds [0:6];
  wire [31:0] rdat, flashData, cmpCalc, cmpRef, opSeen;
  wire ack, flashRd, flashAck, engStart, cmpValid, engDone, keyWe, keyErase, xtsGo;
  wire xtsDecrypt, ledReady, ledFatal, ledBusy, dataOutEn, bootHalt, diagActive;
  wire [17:0] flashAddr;
  wire [3:0] engOp;
  wire [2:0] engKey, keyId;
  wire [7:0] keyFill;
  integer seed = 61833, err_count = 0, samples_checked = 0, i;
  always #20 core_clk = ~core_clk;
  cstg_service_gate #(.FLASH_WORDS(18'h4)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .flashRd(flashRd), .flashAddr(flashAddr),
    .flashData(flashData), .flashAck(flashAck), .engStart(engStart), .engOp(engOp),
    .engKey(engKey), .cmpValid(cmpValid), .cmpCalc(cmpCalc), .cmpRef(cmpRef),
    .engDone(engDone), .keyWe(keyWe), .keyId(keyId), .keyErase(keyErase), .keyFill(keyFill),
    .xtsGo(xtsGo), .xtsDecrypt(xtsDecrypt), .ioActive(ioActive), .ledReady(ledReady),
    .ledFatal(ledFatal), .ledBusy(ledBusy), .dataOutEn(dataOutEn), .bootHalt(bootHalt),
    .diagActive(diagActive));
  cstg_far_side far_u (.core_clk(core_clk), .rst_b(rst_b), .badCrc(badCrc), .slow(slow),
    .failOp(failOp), .seedWord(seedWord), .flashRd(flashRd), .flashAddr(flashAddr),
    .flashData(flashData), .flashAck(flashAck), .engStart(engStart), .engOp(engOp),
    .cmpValid(cmpValid), .cmpCalc(cmpCalc), .cmpRef(cmpRef), .engDone(engDone),
    .opSeen(opSeen));
  function [31:0] stExp(input [1:0] ldr, input [1:0] enc, input [7:0] fl, input fat,
    input rdy);
    stExp = {18'h0, rdy, fat, fl, enc, ldr};
  endfunction
  task chk(input string n, input [31:0] s, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Held until ack is seen high at an edge; only the watchdog ends a hang
  task wb(input [7:0] a, input w, input [31:0] d);
    @(posedge core_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    q = rdat;
    req <= 1'b0;
  endtask
  task poll(input dn);
    wb(`CSTG_ADR_STATUS, 1'b0, 32'h0);
    while (q[14] !== 1'b0 || (dn && q[19] !== 1'b1))
      wb(`CSTG_ADR_STATUS, 1'b0, 32'h0);
  endtask
  task cmd(input [31:0] d, input [31:0] e);
    wb(`CSTG_ADR_CMD, 1'b1, d);
    poll(1'b1);
    wb(`CSTG_ADR_RESP, 1'b0, 32'h0);
    chk("response", q, e);
  endtask
  task rst(input bad, input [4:0] fop);
    @(posedge core_clk);
    rst_b <= 1'b0;
    badCrc <= bad;
    failOp <= fop;
    seedWord <= $random(seed);
    slow <= 1'($random(seed));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    poll(1'b0);
  endtask
  initial begin
    keyCmds = '{32'h10b, 32'h10c, 32'h30c, 32'h10d, 32'h107, 32'h00b, 32'h20c};
    rst(1'b0, 5'h1f);
    chk("status", q & 32'hffff, stExp(2'h1, 2'h3, 8'h00, 1'b0, 1'b1));
    chk("katsRun", opSeen, 32'h7ff);
    chk("ledReady", {31'h0, ledReady}, 32'h1);
    cmd(32'h2, `CSTG_RSP_OK);
    cmd(32'h3, 32'h0);
    cmd(32'ha, `CSTG_RSP_DENIED);
    cmd(32'h00010001, `CSTG_RSP_OK);
    cmd(32'h00010001, `CSTG_RSP_LOGGED);
    cmd(32'h3, 32'h1);
    cmd(32'ha, `CSTG_RSP_OK);
    cmd(32'h9, `CSTG_RSP_OK);
    chk("xtsDecrypt", {31'h0, xtsDecrypt}, 32'h1);
    cmd(32'h6, `CSTG_RSP_DENIED);
    cmd(32'h8, `CSTG_RSP_DENIED);
    failOp <= 5'h0b;
    cmd(32'he, `CSTG_RSP_FWFAIL);
    failOp <= 5'h1f;
    cmd(32'he, `CSTG_RSP_OK);
    for (i = 0; i < 7; i = i + 1)
      cmd(keyCmds[i], `CSTG_RSP_OK);
    cmd(32'h2, `CSTG_RSP_OK);
    cmd(32'h00020001, `CSTG_RSP_OK);
    cmd(32'h00a50006, `CSTG_RSP_OK);
    cmd(32'h4, 32'ha5);
    cmd(32'ha, `CSTG_RSP_DENIED);
    // Message blocks stay idle around diagnostics but here
    ioActive <= 1'b1;
    cmd(32'h8, `CSTG_RSP_IOBUSY);
    ioActive <= 1'b0;
    failOp <= 5'h0e;
    cmd(32'h8, `CSTG_RSP_TESTFAIL);
    cmd(32'h108, `CSTG_RSP_OK);
    failOp <= 5'h1f;
    cmd(32'h8, `CSTG_RSP_OK);
    cmd(32'h108, `CSTG_RSP_TESTFAIL);
    cmd(32'h208, `CSTG_RSP_OK);
    wb(`CSTG_ADR_DIGSEL, 1'b1, 32'h0);
    wb(`CSTG_ADR_DIGEST, 1'b0, 32'h0);
    chk("digest", q, {seedWord[27:0], 4'hf});
    wb(`CSTG_ADR_STATUS, 1'b0, 32'h0);
    chk("diagMode", {30'h0, q[18], diagActive}, 32'h3);
    repeat (4) begin
      wb(8'h80 | 8'($random(seed)), 1'b0, 32'h0);
      chk("unmapped", q, 32'h0);
    end
    // Diagnostics alter the module; reset follows
    rst(1'b0, 5'h06);
    chk("status", q & 32'hffff, stExp(2'h1, 2'h1, 8'h02, 1'b1, 1'b0));
    cmd(32'h00010001, `CSTG_RSP_FATAL);
    rst(1'b1, 5'h1f);
    chk("status", q & 32'hffff, stExp(2'h2, 2'h0, 8'h00, 1'b1, 1'b0));
    chk("bootHalt", {31'h0, bootHalt}, 32'h1);
    summarize;
  end
  initial begin
    #2000000;
    err_count = err_count + 1;
    summarize;
  end
endmodule
